// >>> ufib_pkg.sv
// shared constants for the uart fifo, interrupt and baud block
package ufib_pkg;

  // ---------------------------------------------------------------
  // register word indexes (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_DATA = 4'h0; // rx buffer / tx holding
  localparam logic [3:0] OFS_IEN  = 4'h1; // interrupt enable
  localparam logic [3:0] OFS_IIR  = 4'h2; // ident read, fifo ctrl write
  localparam logic [3:0] OFS_LCR  = 4'h3; // line control
  localparam logic [3:0] OFS_MCR  = 4'h4; // modem control
  localparam logic [3:0] OFS_LSR  = 4'h5; // line status
  localparam logic [3:0] OFS_MSR  = 4'h6; // modem status
  localparam logic [3:0] OFS_SCR  = 4'h7; // scratch
  localparam logic [3:0] OFS_CFG  = 4'h8; // rate configuration

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FCR_EN     = 0;
  localparam int FCR_RX_CLR = 1;
  localparam int FCR_TX_CLR = 2;
  localparam int FCR_DMA    = 3;
  localparam int IEN_RX     = 0;
  localparam int IEN_TX     = 1;
  localparam int IEN_LS     = 2;
  localparam int IEN_MS     = 3;
  localparam int LCR_DLAB   = 7;
  localparam int MCR_DTR    = 0;
  localparam int MCR_RTS    = 1;
  localparam int MCR_RI     = 2;
  localparam int MCR_IRQ_OE = 3;
  localparam int MCR_LOOP   = 4;
  localparam int CFG_HS     = 2;

  // ---------------------------------------------------------------
  // codes and reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] TRIG_1  = 5'h01;
  localparam logic [4:0] TRIG_4  = 5'h04;
  localparam logic [4:0] TRIG_8  = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0E;
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [3:0] IID_LS   = 4'h6;
  localparam logic [3:0] IID_RX   = 4'h4;
  localparam logic [3:0] IID_TO   = 4'hC;
  localparam logic [3:0] IID_TX   = 4'h2;
  localparam logic [3:0] IID_MS   = 4'h0;
  localparam logic [15:0] RST_DIV = 16'h000C;
  localparam logic [3:0] RST_PINS = 4'hF;

  // ---------------------------------------------------------------
  // baud pre-divider: ticks pass at step/13 of the reference rate
  // ---------------------------------------------------------------
  localparam logic [1:0] PREDIV_13   = 2'h0;
  localparam logic [1:0] PREDIV_1625 = 2'h1;
  localparam logic [1:0] PREDIV_1    = 2'h2;
  localparam logic [3:0] PRE_MOD       = 4'hD;
  localparam logic [3:0] PRE_STEP_13   = 4'h1;
  localparam logic [3:0] PRE_STEP_1625 = 4'h8;
  localparam logic [3:0] PRE_STEP_1    = 4'hD;

  // ---------------------------------------------------------------
  // receive timeout: four characters of ten bits at 16x
  // ---------------------------------------------------------------
  localparam int CHAR_BITS = 10;
  localparam int OVERSAMPLE = 16;
  localparam int TO_CHARS = 4;
  localparam int TO_W = 10;
  localparam logic [TO_W-1:0] TO_MAX =
    TO_W'(CHAR_BITS * OVERSAMPLE * TO_CHARS);

endpackage : ufib_pkg

// >>> ufib_baud_gen.sv
// baud generator: selectable pre-divider and 16-bit divisor
`timescale 1ns/1ps
`default_nettype none
module ufib_baud_gen
  import ufib_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // rate selection
  input  wire logic [1:0]  i_prediv_sel,
  input  wire logic        i_high_speed,
  input  wire logic [15:0] i_divisor,
  // sixteen-times bit rate enable
  output logic             o_tick16
);

  typedef struct packed {
    logic [3:0]  acc;
    logic        pre;
    logic [15:0] cnt;
    logic        tick;
  } ufib_baud_s;

  ufib_baud_s st_ff;
  ufib_baud_s nxt_st;
  logic [3:0] step;
  logic [4:0] sum;

  // fractional pre-divider, then divisor countdown
  always_comb
  begin
    step = PRE_STEP_13;
    if (i_high_speed || i_prediv_sel == PREDIV_1)
      step = PRE_STEP_1;
    else if (i_prediv_sel == PREDIV_1625)
      step = PRE_STEP_1625;
    sum = {1'b0, st_ff.acc} + {1'b0, step};
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    nxt_st.pre = (sum >= {1'b0, PRE_MOD});
    nxt_st.acc = nxt_st.pre ? 4'(sum - {1'b0, PRE_MOD}) : sum[3:0];
    // divisor taken only at reload, so a change never cuts a period
    if (st_ff.pre && i_divisor != 16'h0000)
    begin
      if (st_ff.cnt <= 16'h0001)
      begin
        nxt_st.cnt = i_divisor;
        nxt_st.tick = 1'b1;
      end
      else
        nxt_st.cnt = st_ff.cnt - 16'h0001;
    end
  end

  // state register
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign o_tick16 = st_ff.tick;

  // a period of more than one pre-tick never gives back-to-back ticks
  a_tick_spacing: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (o_tick16 && st_ff.cnt > 16'h0001) |=> !o_tick16)
    else $error("baud tick repeated inside a divisor period");

endmodule : ufib_baud_gen
`default_nettype wire

// >>> ufib_irq_prio.sv
// interrupt priority encoder for the identification register
`timescale 1ns/1ps
`default_nettype none
module ufib_irq_prio
  import ufib_pkg::*;
(
  // enabled pending sources
  input  wire logic       i_fifo_en,
  input  wire logic       i_ls,
  input  wire logic       i_rx,
  input  wire logic       i_to,
  input  wire logic       i_tx,
  input  wire logic       i_ms,
  // identity of the winner
  output logic [3:0]      o_iid,
  output logic            o_any
);

  // fixed priority: line status, data, timeout, tx empty, modem
  always_comb
  begin
    o_any = i_ls | i_rx | i_to | i_tx | i_ms;
    if (i_ls)
      o_iid = IID_LS;
    else if (i_rx)
      o_iid = IID_RX;
    else if (i_to && i_fifo_en)
      o_iid = IID_TO;
    else if (i_tx)
      o_iid = IID_TX;
    else if (i_ms)
      o_iid = IID_MS;
    else
      o_iid = IID_NONE;
  end

endmodule : ufib_irq_prio
`default_nettype wire

// >>> ufib_top.sv
// uart fifo control, interrupt, enable, divisor and scratch registers
`timescale 1ns/1ps
`default_nettype none
// Function
// - fifo control 7:6 picks receive trigger level
// - control bit 3 selects dma mode 1
// - bit 2 pulses transmit fifo counter clear
// - bit 1 pulses receive fifo counter clear
// - control bit 0 enables fifo mode
// - ident 7:6 show fifo mode, 5:4 zero
// - ident bit 0 high when nothing pending
// - timeout code only in fifo mode
// - line status first, cleared by reading it
// - four idle characters raise timeout, read clears
// - tx empty fourth, write or ident read clears
// - modem status last, cleared by reading it
// - enable bits gate each interrupt source
// - enable bits 7:4 read zero
// - normal speed predivides by thirteen then divisor
// - generator output is sixteen times bit rate
// - high speed applies divisor without predivision
// - predivider selectable 13, 1.625 or 1
// - scratch byte reads back last write
// - modem control bit 3 drives irq, loops carrier
module ufib_top
  import ufib_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // avalon-mm register slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // receive datapath
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_ready,
  input  wire logic [4:0]  i_rx_level,
  input  wire logic        i_rx_push,
  input  wire logic        i_err_overrun,
  input  wire logic        i_err_parity,
  input  wire logic        i_err_stop,
  input  wire logic        i_err_silent,
  output logic             o_rx_rd,
  // transmit datapath
  input  wire logic        i_tx_empty,
  output logic             o_tx_wr,
  output logic [7:0]       o_tx_data,
  // fifo and line control
  output logic             o_fifo_en,
  output logic             o_dma_mode,
  output logic             o_tx_fifo_clr,
  output logic             o_rx_fifo_clr,
  output logic [7:0]       o_line_ctrl,
  output logic             o_baud16_en,
  // modem pins
  input  wire logic        i_cts_n,
  input  wire logic        i_dsr_n,
  input  wire logic        i_ri_n,
  input  wire logic        i_dcd_n,
  output logic             o_rts_n,
  output logic             o_dtr_n,
  output logic             o_loopback,
  // interrupt pin
  output logic             o_irq,
  output logic             o_irq_oe_n
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]      ien;
    logic            fifo_en;
    logic            dma;
    logic [1:0]      trig;
    logic            tx_clr;
    logic            rx_clr;
    logic [7:0]      lcr;
    logic [4:0]      mcr;
    logic [7:0]      scratch;
    logic [15:0]     div;
    logic [2:0]      cfg;
    logic [3:0]      ls_flags;
    logic [3:0]      ms_flags;
    logic [3:0]      ms_prev;
    logic [3:0]      sync1;
    logic [3:0]      sync2;
    logic            tx_pend;
    logic            tx_empty_q;
    logic [TO_W-1:0] to_cnt;
    logic            wreq;
    logic [7:0]      rdata;
    logic            tx_wr;
    logic [7:0]      tx_data;
    logic            rx_rd;
    logic            irq;
    logic            irq_oe_n;
    logic [1:0]      pins_n;
  } ufib_regs_s;

  ufib_regs_s st_ff;
  ufib_regs_s nxt_st;

  logic       acc;
  logic       rd_ok;
  logic       wr_ok;
  logic       dlab;
  logic [7:0] wdata;
  logic [3:0] mst;
  logic [3:0] ms_evt;
  logic       rx_pend;
  logic       to_hit;
  logic       pend_ls;
  logic       pend_rx;
  logic       pend_to;
  logic       pend_tx;
  logic       pend_ms;
  logic [3:0] iid;
  logic       any;
  logic       tick16;

  // receive trigger depth from the two control bits
  function automatic logic [4:0] trig_bytes(input logic [1:0] code);
    case (code)
      2'h0:    trig_bytes = TRIG_1;
      2'h1:    trig_bytes = TRIG_4;
      2'h2:    trig_bytes = TRIG_8;
      default: trig_bytes = TRIG_14;
    endcase
  endfunction : trig_bytes

  // ---------------------------------------------------------------
  // bus decode and source qualification
  // ---------------------------------------------------------------

  // a request acts once, in its first cycle while waitrequest is high
  assign acc   = st_ff.wreq & (i_avs_read | i_avs_write);
  assign rd_ok = acc & i_avs_read;
  assign wr_ok = acc & i_avs_write & i_avs_byteenable[0];
  assign dlab  = st_ff.lcr[LCR_DLAB];
  assign wdata = i_avs_writedata[7:0];

  // modem inputs, looped back from modem control in diagnostic mode
  assign mst = st_ff.mcr[MCR_LOOP] ?
    {st_ff.mcr[MCR_IRQ_OE], st_ff.mcr[MCR_RI],
     st_ff.mcr[MCR_DTR], st_ff.mcr[MCR_RTS]} : ~st_ff.sync2;
  // ring flag on the trailing edge of ring, all others on any change
  assign ms_evt = {mst[3] ^ st_ff.ms_prev[3],
                   st_ff.ms_prev[2] & ~mst[2],
                   mst[1:0] ^ st_ff.ms_prev[1:0]};

  // data source: single byte ready, or fifo at its trigger depth
  assign rx_pend = st_ff.fifo_en ?
    (i_rx_level >= trig_bytes(st_ff.trig)) : i_rx_ready;
  assign to_hit  = st_ff.fifo_en & (i_rx_level != 5'h00) &
                   (st_ff.to_cnt == TO_MAX);

  // each enable bit gates one source, except the receive bit, which gates data and timeout
  assign pend_ls = st_ff.ien[IEN_LS] & (|st_ff.ls_flags);
  assign pend_rx = st_ff.ien[IEN_RX] & rx_pend;
  assign pend_to = st_ff.ien[IEN_RX] & to_hit;
  assign pend_tx = st_ff.ien[IEN_TX] & st_ff.tx_pend;
  assign pend_ms = st_ff.ien[IEN_MS] & (|st_ff.ms_flags);

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------

  // priority encoder for the identification code
  ufib_irq_prio u_prio (
    .i_fifo_en (st_ff.fifo_en),
    .i_ls      (pend_ls),
    .i_rx      (pend_rx),
    .i_to      (pend_to),
    .i_tx      (pend_tx),
    .i_ms      (pend_ms),
    .o_iid     (iid),
    .o_any     (any)
  );

  // sixteen-times bit clock enable
  ufib_baud_gen u_baud (
    .i_sys_clk    (i_sys_clk),
    .i_rst_n      (i_rst_n),
    .i_prediv_sel (st_ff.cfg[1:0]),
    .i_high_speed (st_ff.cfg[CFG_HS]),
    .i_divisor    (st_ff.div),
    .o_tick16     (tick16)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------

  // clears are applied first so that a same-cycle event still sets
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.tx_clr = 1'b0;
    nxt_st.rx_clr = 1'b0;
    nxt_st.tx_wr = 1'b0;
    nxt_st.rx_rd = 1'b0;
    nxt_st.wreq = ~acc;
    nxt_st.sync1 = {i_dcd_n, i_ri_n, i_dsr_n, i_cts_n};
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.ms_prev = mst;
    nxt_st.tx_empty_q = i_tx_empty;
    nxt_st.irq = any;
    // reads and their side effects
    if (rd_ok)
    begin
      case (i_avs_address)
        OFS_DATA:
          if (dlab)
            nxt_st.rdata = st_ff.div[7:0];
          else
          begin
            nxt_st.rdata = i_rx_data;
            nxt_st.rx_rd = 1'b1;
          end
        OFS_IEN:
          nxt_st.rdata = dlab ? st_ff.div[15:8] :
                         {4'h0, st_ff.ien};
        OFS_IIR:
        begin
          nxt_st.rdata = {{2{st_ff.fifo_en}}, 2'b00,
                          iid[3] & st_ff.fifo_en, iid[2:0]};
          if (iid == IID_TX)
            nxt_st.tx_pend = 1'b0;
        end
        OFS_LCR: nxt_st.rdata = st_ff.lcr;
        OFS_MCR: nxt_st.rdata = {3'h0, st_ff.mcr};
        OFS_LSR:
        begin
          nxt_st.rdata = {2'b00, i_tx_empty, st_ff.ls_flags,
                          i_rx_ready};
          nxt_st.ls_flags = 4'h0;
        end
        OFS_MSR:
        begin
          nxt_st.rdata = {mst, st_ff.ms_flags};
          nxt_st.ms_flags = 4'h0;
        end
        OFS_SCR: nxt_st.rdata = st_ff.scratch;
        OFS_CFG: nxt_st.rdata = {5'h00, st_ff.cfg};
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    // writes
    if (wr_ok)
    begin
      case (i_avs_address)
        OFS_DATA:
          if (dlab)
            nxt_st.div[7:0] = wdata;
          else
          begin
            nxt_st.tx_wr = 1'b1;
            nxt_st.tx_data = wdata;
            nxt_st.tx_pend = 1'b0;
          end
        OFS_IEN:
          if (dlab)
            nxt_st.div[15:8] = wdata;
          else
          begin
            nxt_st.ien = wdata[3:0];
            // enabling while already empty reports it at once
            if (wdata[IEN_TX] && !st_ff.ien[IEN_TX] && i_tx_empty)
              nxt_st.tx_pend = 1'b1;
          end
        OFS_IIR:
        begin
          nxt_st.fifo_en = wdata[FCR_EN];
          nxt_st.trig = wdata[7:6];
          nxt_st.dma = wdata[FCR_DMA] & wdata[FCR_EN];
          nxt_st.tx_clr = wdata[FCR_TX_CLR];
          nxt_st.rx_clr = wdata[FCR_RX_CLR];
        end
        OFS_LCR: nxt_st.lcr = wdata;
        OFS_MCR: nxt_st.mcr = wdata[4:0];
        OFS_SCR: nxt_st.scratch = wdata;
        OFS_CFG: nxt_st.cfg = wdata[2:0];
        default: nxt_st.rdata = st_ff.rdata;
      endcase
    end
    // hardware sets, after the software clears
    nxt_st.ls_flags = nxt_st.ls_flags |
      {i_err_silent, i_err_stop, i_err_parity, i_err_overrun};
    nxt_st.ms_flags = nxt_st.ms_flags | ms_evt;
    if (i_tx_empty && !st_ff.tx_empty_q)
      nxt_st.tx_pend = 1'b1;
    // idle time since the last fifo access, counted in 16x ticks
    if (i_rx_push || nxt_st.rx_rd || i_rx_level == 5'h00 ||
        !st_ff.fifo_en)
      nxt_st.to_cnt = '0;
    else if (tick16 && st_ff.to_cnt != TO_MAX)
      nxt_st.to_cnt = st_ff.to_cnt + 1'b1;
    // pin drivers; modem outputs go inactive in diagnostic mode
    nxt_st.irq_oe_n = ~nxt_st.mcr[MCR_IRQ_OE];
    nxt_st.pins_n = nxt_st.mcr[MCR_LOOP] ? 2'b11 :
      ~{nxt_st.mcr[MCR_RTS], nxt_st.mcr[MCR_DTR]};
  end

  // state register with synchronous reset
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      st_ff <= '0;
      st_ff.div <= RST_DIV;
      st_ff.sync1 <= RST_PINS;
      st_ff.sync2 <= RST_PINS;
      st_ff.wreq <= 1'b1;
      st_ff.irq_oe_n <= 1'b1;
      st_ff.pins_n <= 2'b11;
    end
    else
      st_ff <= nxt_st;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_avs_readdata    = {24'h000000, st_ff.rdata};
  assign o_avs_waitrequest = st_ff.wreq;
  assign o_rx_rd           = st_ff.rx_rd;
  assign o_tx_wr           = st_ff.tx_wr;
  assign o_tx_data         = st_ff.tx_data;
  assign o_fifo_en         = st_ff.fifo_en;
  assign o_dma_mode        = st_ff.dma;
  assign o_tx_fifo_clr     = st_ff.tx_clr;
  assign o_rx_fifo_clr     = st_ff.rx_clr;
  assign o_line_ctrl       = st_ff.lcr;
  assign o_baud16_en       = tick16;
  assign o_rts_n           = st_ff.pins_n[1];
  assign o_dtr_n           = st_ff.pins_n[0];
  assign o_loopback        = st_ff.mcr[MCR_LOOP];
  assign o_irq             = st_ff.irq;
  assign o_irq_oe_n        = st_ff.irq_oe_n;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ident_upper: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (rd_ok && i_avs_address == OFS_IIR) |=>
      (o_avs_readdata[5:4] == 2'b00 &&
       o_avs_readdata[7:6] == {2{o_fifo_en}}))
    else $error("ident upper bits wrong");

  a_ident_none: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (rd_ok && i_avs_address == OFS_IIR) |=>
      (o_avs_readdata[0] == !$past(any)))
    else $error("ident bit 0 disagrees with pending state");

  a_ident_tout: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (rd_ok && i_avs_address == OFS_IIR && !st_ff.fifo_en) |=>
      !o_avs_readdata[3])
    else $error("timeout code outside fifo mode");

  a_line_first: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    pend_ls |-> (iid == IID_LS && any))
    else $error("line status not reported first");

  a_enable_upper: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (rd_ok && i_avs_address == OFS_IEN && !dlab) |=>
      (o_avs_readdata[7:4] == 4'h0))
    else $error("enable upper bits not zero");

  a_clr_pulse: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (wr_ok && i_avs_address == OFS_IIR && wdata[FCR_TX_CLR]) |=>
      o_tx_fifo_clr ##1 !o_tx_fifo_clr)
    else $error("tx fifo clear not a single pulse");

  a_rclr_pulse: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (wr_ok && i_avs_address == OFS_IIR && wdata[FCR_RX_CLR]) |=>
      o_rx_fifo_clr ##1 !o_rx_fifo_clr)
    else $error("rx fifo clear not a single pulse");

  a_dma_needs: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    o_dma_mode |-> o_fifo_en)
    else $error("dma mode 1 without fifo mode");

  a_irq_gate: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    (wr_ok && i_avs_address == OFS_MCR) |=>
      (o_irq_oe_n == !$past(wdata[MCR_IRQ_OE])))
    else $error("irq drive does not follow modem control");

  a_bus_answer: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n)
    acc |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one cycle after request");

endmodule : ufib_top
`default_nettype wire

// >>> ufib_far_end.sv
// far-end model: receive-side events and the cts modem pin
`timescale 1ns/1ps
`default_nettype none
module ufib_far_end (
  // clock and bench commands
  input  wire logic       i_sys_clk,
  input  wire logic       i_err_go,
  input  wire logic [1:0] i_err_kind,
  input  wire logic       i_push,
  input  wire logic       i_rd,
  input  wire logic       i_clr,
  input  wire logic       i_cts,
  // toward the block
  output logic [3:0]      o_err,
  output logic [4:0]      o_level,
  output logic            o_push,
  output logic            o_cts_n
);
  // quiet line at time zero
  initial
  begin
    o_err = 4'h0;
    o_level = 5'h00;
    o_push = 1'b0;
    o_cts_n = 1'b1;
  end
  // events last one cycle; level counts bytes held
  always @(posedge i_sys_clk)
  begin
    o_err   <= i_err_go ? 4'h1 << i_err_kind : 4'h0;
    o_push  <= i_push;
    o_level <= i_clr ? 5'h00 : o_level + 5'(i_push) - 5'(i_rd);
    o_cts_n <= !i_cts;
  end
endmodule : ufib_far_end
`default_nettype wire

// >>> ufib_top_tb_top.sv
// self-checking bench for the uart register block
`timescale 1ns/1ps
`default_nettype none
module ufib_top_tb_top
  import ufib_pkg::*;
;
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, go = 0, psh = 0;
  logic        cts = 0, txe = 0;
  logic [3:0]  adr = 0, be = 4'hF;
  logic [1:0]  kind = 0;
  logic [7:0]  wd = 0, sv, dv;
  wire  logic [31:0] rdata;
  wire  logic  wreq, rx_rd, irq, oe_n, fen, dma, rclr, b16, push_p, cts_n;
  wire  logic [3:0] err;
  wire  logic [4:0] lvl;
  wire  logic  txw, tclr, rts_n, dtr_n, lpb;
  wire  logic [7:0] txd, lc;
  logic [7:0]  txq = 0;
  int          tcn = 0;
  int          failures = 0, check_count = 0;
  logic [31:0] expq[$];

  ufib_top u_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(be),
    .i_avs_writedata({24'h0, wd}), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_rx_data(8'h5A),
    .i_rx_ready(lvl != 5'h00), .i_rx_level(lvl), .i_rx_push(push_p),
    .i_err_overrun(err[0]), .i_err_parity(err[1]),
    .i_err_stop(err[2]), .i_err_silent(err[3]), .o_rx_rd(rx_rd),
    .i_tx_empty(txe), .o_tx_wr(txw), .o_tx_data(txd), .o_fifo_en(fen),
    .o_dma_mode(dma), .o_tx_fifo_clr(tclr), .o_rx_fifo_clr(rclr),
    .o_line_ctrl(lc), .o_baud16_en(b16), .i_cts_n(cts_n),
    .i_dsr_n(1'b1), .i_ri_n(1'b1), .i_dcd_n(1'b1), .o_rts_n(rts_n),
    .o_dtr_n(dtr_n), .o_loopback(lpb), .o_irq(irq), .o_irq_oe_n(oe_n));

  ufib_far_end u_far (
    .i_sys_clk(clk), .i_err_go(go), .i_err_kind(kind), .i_push(psh),
    .i_rd(rx_rd), .i_clr(rclr), .i_cts(cts), .o_err(err),
    .o_level(lvl), .o_push(push_p), .o_cts_n(cts_n));

  // 10 MHz clock
  initial
    forever #50 clk = ~clk;

  // transmit byte and clear pulses as the far side would see them
  always @(posedge clk)
  begin
    if (txw === 1'b1)
      txq <= txd;
    if (tclr === 1'b1)
      tcn <= tcn + 1;
  end

  task automatic stop_test();
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one bus cycle, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [7:0] d);
    int n;
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    rd <= 0;
    wr <= 0;
    // let one edge pass so a following request never reuses this step
    @(posedge clk);
    if (n >= 50)
    begin
      failures++;
      stop_test();
    end
  endtask : acc

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    expq.push_back({24'h0, e});
    acc(0, a, 8'h00);
  endtask : rdc

  // cycles from one tick to the k-th after, skipping a reload
  task automatic span(input int k, input int e);
    int n, t;
    n = 0;
    t = 0;
    while (t < k + 2 && n < 9000)
    begin
      @(posedge clk);
      n++;
      if (b16 === 1'b1)
      begin
        t++;
        if (t == 2) n = 0;
      end
    end
    chk("tick_span", e, n);
  endtask : span

  task automatic pulse_wait(input int c);
    @(posedge clk);
    go <= 0;
    psh <= 0;
    repeat (c) @(posedge clk);
  endtask : pulse_wait

  // read answers are matched to the oldest note
  always @(posedge clk)
    if (rd && wreq === 1'b0)
      chk("readdata", expq.pop_front(), rdata);

  initial
  begin
    void'($urandom(32'hfbc4));
    sv = 8'($urandom);
    dv = 8'(1 + $urandom % 30);
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rdc(OFS_IIR, 8'h01);
    rdc(4'h9, 8'h00);
    acc(1, OFS_IEN, 8'hF0);
    rdc(OFS_IEN, 8'h00);
    acc(1, OFS_SCR, sv);
    rdc(OFS_SCR, sv);
    be <= 4'h0;
    acc(1, OFS_SCR, ~sv);
    be <= 4'hF;
    rdc(OFS_SCR, sv);
    // divisor bytes and the rate in every pre-divider mode
    acc(1, OFS_LCR, 8'h80);
    acc(1, OFS_DATA, dv);
    acc(1, OFS_IEN, 8'h00);
    rdc(OFS_DATA, dv);
    rdc(OFS_IEN, 8'h00);
    acc(1, OFS_LCR, 8'h03);
    chk("line_ctrl", 8'h03, lc);
    for (int m = 0; m < 4; m++)
    begin
      acc(1, OFS_CFG, (m == 3) ? 8'h04 : 8'(m));
      span(m == 1 ? 8 : 1, (m < 2) ? 13 * dv : dv);
    end
    // fifo mode, then each line error in turn
    acc(1, OFS_MCR, 8'h0B);
    chk("pins", 3'b000, {rts_n, dtr_n, lpb});
    chk("irq_oe_n", 0, oe_n);
    acc(1, OFS_IIR, 8'h01);
    chk("fifo_en", 1, fen);
    rdc(OFS_IIR, 8'hC1);
    acc(1, OFS_IEN, 8'h04);
    for (int k = 0; k < 4; k++)
    begin
      kind <= 2'(k);
      go <= 1;
      pulse_wait(3);
      chk("irq", 1, irq);
      rdc(OFS_IIR, 8'hC6);
      rdc(OFS_LSR, 8'h02 << k);
      rdc(OFS_IIR, 8'hC1);
    end
    // trigger of four, counter clear, then timeout
    acc(1, OFS_IEN, 8'h01);
    acc(1, OFS_IIR, 8'h49);
    chk("dma_mode", 1, dma);
    for (int k = 0; k < 4; k++)
    begin
      rdc(OFS_IIR, 8'hC1);
      psh <= 1;
      pulse_wait(3);
    end
    rdc(OFS_IIR, 8'hC4);
    acc(1, OFS_IIR, 8'h4F);
    chk("tx_clr_count", 1, tcn);
    pulse_wait(2);
    rdc(OFS_IIR, 8'hC1);
    psh <= 1;
    pulse_wait(640 * dv + 60);
    rdc(OFS_IIR, 8'hCC);
    rdc(OFS_DATA, 8'h5A);
    pulse_wait(2);
    rdc(OFS_IIR, 8'hC1);
    // transmit empty, then modem change
    txe <= 1;
    acc(1, OFS_IEN, 8'h02);
    rdc(OFS_IIR, 8'hC2);
    rdc(OFS_IIR, 8'hC1);
    acc(1, OFS_IEN, 8'h0A);
    acc(1, OFS_DATA, 8'h33);
    chk("tx_data", 8'h33, txq);
    rdc(OFS_IIR, 8'hC1);
    cts <= 1;
    pulse_wait(6);
    rdc(OFS_IIR, 8'hC0);
    rdc(OFS_MSR, 8'h11);
    rdc(OFS_IIR, 8'hC1);
    acc(1, OFS_MCR, 8'h1B);
    chk("pins", 3'b111, {rts_n, dtr_n, lpb});
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule : ufib_top_tb_top
`default_nettype wire
